// *** logic/tss_pkg.sv ***
// Purpose: Shared constants and types for the trunk supervision sequencer
// Assumes: 250 MHz system clock
// Notes:   Times kept in ms, cycle counts derived from them
package tss_pkg;
    localparam int unsigned ClkHz      = 250_000_000;
    localparam int unsigned CycPerMs   = ClkHz / 1000;
    localparam int unsigned DelayMinMs = 256;
    localparam int unsigned DelayMaxMs = 384;
    localparam int unsigned DelayMs    = 320;
    localparam int unsigned WinkMs     = 250;
    localparam int unsigned WinkLagMs  = 192;
    localparam int unsigned DelayCyc   = DelayMs * CycPerMs;
    localparam int unsigned WinkCyc    = WinkMs * CycPerMs;
    localparam int unsigned WinkLagCyc = WinkLagMs * CycPerMs;
    localparam int unsigned DebCyc     = 16;
    localparam int unsigned Pps20Cyc   = 25 * CycPerMs;
    localparam int unsigned Pps10Cyc   = 50 * CycPerMs;
    localparam int unsigned Pps10bCyc  = 50 * CycPerMs;

    typedef enum logic [1:0] {
        immediate_start_code = 2'h0,
        delay_dial_code      = 2'h1,
        wink_start_code      = 2'h2
    } tss_start_t;

    typedef enum logic [1:0] {
        TYPE_ONE               = 2'h0,
        TYPE_TWO               = 2'h1,
        duplex_lead_signaling  = 2'h2
    } tss_sig_t;

    typedef enum logic [1:0] {
        party_release_a  = 2'h0,
        ORIG_RELEASE     = 2'h1,
        JOINT_RELEASE    = 2'h2
    } tss_rel_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_OUT   = 3'h1,
        ST_TALK  = 3'h3,
        ST_INC   = 3'h2,
        ST_START = 3'h6,
        ST_REL   = 3'h4
    } tss_state_t;

    typedef struct packed {
        tss_sig_t   sigType;
        tss_start_t startMode;
        tss_rel_t   nearRel;
        tss_rel_t   farRel;
        logic [1:0] pulseRate;
        logic       echoReq;
    } tss_cfg_t;
endpackage

// *** logic/trunk_supervision_sequencer.sv ***
// Overview of operation
// - Idle: send lead ground, open receive idle
// - Outgoing Type I seizure sets battery
// - Receive ground while seized means answer
// - Three selectable incoming start arrangements
// - Immediate start returns no start signal
// - Delay dial: 256-384 ms off-hook then on-hook
// - Wink 250 ms, begins 128-256 ms
// - Type II uses contact and current sense
// - Echo control blocked under Type II
// - Release per far option; near option not used
// - DX outgoing seizure current, pulses interrupt
// - DX answer drops detector low
// - DX incoming seizure detector low
// - DX near release waits far on-hook
// - Report each receive state change
// - Outpulse at 20, 10 or 10 pps
// Purpose: Supervisory signaling sequencer for one trunk unit
// Assumes: Controller strobes are one-cycle pulses on clk
// Notes:   sendLead high = battery/contact closed/current on
`timescale 1ns/10ps
`default_nettype none
module trunk_supervision_sequencer
    import tss_pkg::*;
#(
    parameter int unsigned DelayCycP   = DelayCyc,
    parameter int unsigned WinkCycP    = WinkCyc,
    parameter int unsigned WinkLagCycP = WinkLagCyc,
    parameter int unsigned PulseCycP   = Pps20Cyc
)(
    input  wire logic     clk,
    input  wire logic     rst_b,
    input  wire tss_cfg_t cfg,
    input  wire logic     rxLead,
    input  wire logic     seizeReq,
    input  wire logic     releaseReq,
    input  wire logic     digitStb,
    input  wire logic [3:0] digitVal,
    output logic          sendLead,
    output logic          echoEn,
    output logic          answered,
    output logic          farSeized,
    output logic          busy,
    output logic          msgStb,
    output logic          msgLevel
);
    typedef struct packed {
        logic [1:0]  sync;
        logic        rxStable;
        logic [4:0]  debCnt;
        tss_state_t  state;
        logic [31:0] tmr;
        logic [4:0]  pulsesLeft;
        logic        pulsing;
        logic        sendLead;
        logic        echoEn;
        logic        answered;
        logic        farSeized;
        logic        msgStb;
        logic        nearDone;
        logic        startDone;
    } tss_regs_t;

    tss_regs_t s_q;
    tss_regs_t s_d;
    logic      rxRaw;
    logic      offHook;

    function automatic logic [31:0] pulseHalf(input logic [1:0] rate);
        pulseHalf = (rate == 2'h0) ? 32'(PulseCycP) : 32'(2 * PulseCycP);
    endfunction

    // Receive lead mapped to far off-hook: E lead ground, Type II current,
    // DX detector low; open/high reads as idle
    assign rxRaw   = s_q.sync[1];
    assign offHook = (cfg.sigType == duplex_lead_signaling) ? !s_q.rxStable : s_q.rxStable;

    always_comb
    begin
        s_d = s_q;
        s_d.msgStb = 1'b0;
        s_d.sync = {s_q.sync[0], rxLead};
        // **********************
        // Debounce
        // **********************
        if (rxRaw == s_q.rxStable)
        begin
            s_d.debCnt = '0;
        end
        else if (s_q.debCnt == 5'(DebCyc - 1))
        begin
            s_d.debCnt   = '0;
            s_d.rxStable = rxRaw;
            s_d.msgStb   = 1'b1;
        end
        else
        begin
            s_d.debCnt = s_q.debCnt + 5'h1;
        end
        s_d.echoEn = cfg.echoReq && (cfg.sigType != TYPE_TWO);
        if (s_q.tmr != '0)
        begin
            s_d.tmr = s_q.tmr - 32'h1;
        end
        // **********************
        // Sequencer
        // **********************
        case (s_q.state)
            ST_IDLE:
            begin
                s_d.sendLead  = 1'b0;
                s_d.answered  = 1'b0;
                s_d.nearDone  = 1'b0;
                s_d.startDone = 1'b0;
                s_d.farSeized = 1'b0;
                if (offHook)
                begin
                    s_d.farSeized = 1'b1;
                    s_d.state     = ST_INC;
                    s_d.tmr       = (cfg.startMode == wink_start_code) ?
                                    32'(WinkLagCycP) : '0;
                    if (cfg.startMode == delay_dial_code)
                    begin
                        s_d.sendLead = 1'b1;
                        s_d.tmr      = 32'(DelayCycP - 1);
                        s_d.state    = ST_START;
                    end
                end
                else if (seizeReq)
                begin
                    s_d.sendLead = 1'b1;
                    s_d.state    = ST_OUT;
                end
            end
            ST_OUT:
            begin
                if (s_q.pulsing)
                begin
                    if (s_q.tmr == '0)
                    begin
                        s_d.sendLead = !s_q.sendLead;
                        s_d.tmr      = pulseHalf(cfg.pulseRate);
                        if (s_q.sendLead)
                        begin
                            s_d.pulsesLeft = s_q.pulsesLeft - 5'h1;
                        end
                        else if (s_q.pulsesLeft == '0)
                        begin
                            s_d.pulsing = 1'b0;
                        end
                    end
                end
                else if (digitStb)
                begin
                    s_d.pulsing    = 1'b1;
                    s_d.pulsesLeft = (digitVal == 4'h0) ? 5'ha : {1'b0, digitVal};
                    s_d.tmr        = '0;
                end
                else if (offHook)
                begin
                    s_d.answered = 1'b1;
                    s_d.state    = ST_TALK;
                end
                if (releaseReq)
                begin
                    s_d.sendLead = 1'b0;
                    s_d.pulsing  = 1'b0;
                    s_d.state    = ST_REL;
                end
            end
            ST_START:
            begin
                if (s_q.tmr == '0)
                begin
                    s_d.sendLead = !s_q.sendLead;
                    s_d.tmr      = (cfg.startMode == wink_start_code && !s_q.sendLead) ?
                                   32'(WinkCycP - 1) : '0;
                    if (s_q.sendLead)
                    begin
                        s_d.startDone = 1'b1;
                        s_d.state     = ST_INC;
                    end
                end
            end
            ST_INC:
            begin
                if (cfg.startMode == wink_start_code && s_q.tmr == '0 && !s_q.startDone)
                begin
                    s_d.state = ST_START;
                end
                if (cfg.startMode == immediate_start_code)
                begin
                    s_d.sendLead = 1'b0;
                end
                if (seizeReq)
                begin
                    s_d.sendLead = 1'b1;
                    s_d.answered = 1'b1;
                    s_d.state    = ST_TALK;
                end
                else if (!offHook && s_q.tmr == '0 &&
                         (releaseReq || cfg.farRel != JOINT_RELEASE))
                begin
                    s_d.state = ST_IDLE;
                end
            end
            ST_TALK:
            begin
                if (releaseReq)
                begin
                    s_d.nearDone = 1'b1;
                    s_d.state    = ST_REL;
                    // Far side keeps control under joint release
                    if (cfg.farRel == JOINT_RELEASE)
                    begin
                        s_d.state = ST_TALK;
                    end
                    else
                    begin
                        s_d.sendLead = !s_q.farSeized && (cfg.sigType == duplex_lead_signaling);
                    end
                end
                else if (!offHook && (s_q.farSeized || cfg.farRel == party_release_a))
                begin
                    s_d.sendLead = 1'b0;
                    s_d.state    = ST_REL;
                end
            end
            ST_REL:
            begin
                s_d.sendLead = 1'b0;
                if (!offHook)
                begin
                    s_d.state = ST_IDLE;
                end
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_q <= '{state: ST_IDLE, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sendLead  = s_q.sendLead;
    assign echoEn    = s_q.echoEn;
    assign answered  = s_q.answered;
    assign farSeized = s_q.farSeized;
    assign busy      = (s_q.state != ST_IDLE);
    assign msgStb    = s_q.msgStb;
    assign msgLevel  = s_q.rxStable;

    // **********************
    // Checks
    // **********************
    idle_ground_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == ST_IDLE && $past(s_q.state) == ST_IDLE) |-> !sendLead)
        else $error("send lead active in idle");
    echo_block_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg.sigType == TYPE_TWO |=> !echoEn)
        else $error("echo control under type two");
    seize_out_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == ST_IDLE && !offHook && seizeReq) |=> sendLead)
        else $error("outgoing seizure missing");
    msg_change_a: assert property (@(posedge clk) disable iff (!rst_b)
        msgStb |-> msgLevel != $past(msgLevel))
        else $error("message without change");
    deb_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(msgLevel) |-> $past(rxRaw, 2) == msgLevel)
        else $error("undebounced change");
    dd_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == ST_IDLE && offHook && cfg.startMode == delay_dial_code) |=> sendLead)
        else $error("delay dial not immediate");
    answer_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == ST_OUT && !s_q.pulsing && !digitStb && offHook && !releaseReq)
        |=> answered)
        else $error("answer missed");
    rel_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == ST_REL) |=> !sendLead)
        else $error("lead active in release");
endmodule
`default_nettype wire

// *** dv/tss_far_end.sv ***
// Purpose: Far-end trunk model driving the receive detector
// Assumes: offHook from bench, sampled level only
// Notes:   DX far end shows off-hook as detector low
`timescale 1ns/10ps
`default_nettype none
module tss_far_end
    import tss_pkg::*;
(
    input  wire logic     clk,
    input  wire tss_sig_t sigType,
    input  wire logic     offHook,
    input  wire logic     sendLead,
    output logic          rxLead,
    output logic          nearOff
);
    // ****************
    // Lead mapping
    // ****************
    // E ground or pair shorted when off hook
    always_comb rxLead = (sigType == duplex_lead_signaling) ? ~offHook : offHook;
    // Near end state as seen at far end
    always_ff @(posedge clk) nearOff <= sendLead;
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the trunk supervision sequencer
// Assumes: Short sim timing parameters
// Notes:   Inputs change on falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import tss_pkg::*;
;
    localparam int unsigned Dly = 50;
    localparam int unsigned Wink_start_code = 40;
    localparam int unsigned Lag = 30;
    logic       clk;
    logic       rst_b;
    tss_cfg_t   cfg;
    logic       offHook;
    logic       rxLead;
    logic       seizeReq;
    logic       releaseReq;
    logic       digitStb;
    logic [3:0] digitVal;
    logic       sendLead;
    logic       echoEn;
    logic       answered;
    logic       farSeized;
    logic       busy;
    logic       msgStb;
    logic       msgLevel;
    int         fails;
    int         samples_checked;

    trunk_supervision_sequencer #(.DelayCycP(Dly), .WinkCycP(Wink_start_code), .WinkLagCycP(Lag),
        .PulseCycP(20)) trunk_supervision_sequencer_inst (.clk(clk), .rst_b(rst_b),
        .cfg(cfg), .rxLead(rxLead), .seizeReq(seizeReq), .releaseReq(releaseReq),
        .digitStb(digitStb), .digitVal(digitVal), .sendLead(sendLead), .echoEn(echoEn),
        .answered(answered), .farSeized(farSeized), .busy(busy), .msgStb(msgStb),
        .msgLevel(msgLevel));
    tss_far_end tss_far_end_inst (.clk(clk), .sigType(cfg.sigType), .offHook(offHook),
        .sendLead(sendLead), .rxLead(rxLead), .nearOff());

    // ****************
    // Shared tasks
    // ****************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic waitSig(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000)
        begin
            fails++;
            print_verdict();
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_out();
        int falls;
        logic prev;
        falls = 0;
        cfg.sigType = TYPE_ONE;
        pulse(seizeReq);
        chk("seize", sendLead, 1'b1);
        digitVal = 4'h2;
        pulse(digitStb);
        prev = sendLead;
        repeat (600)
        begin
            @(negedge clk);
            if (prev === 1'b1 && sendLead === 1'b0)
                falls++;
            prev = sendLead;
        end
        chk("pulses", falls[15:0], 16'h0002);
        chk("held", sendLead, 1'b1);
        offHook = 1'b1;
        waitSig(answered, 1'b1);
        chk("answer", answered, 1'b1);
        chk("msgLevel", msgLevel, 1'b1);
        pulse(releaseReq);
        offHook = 1'b0;
        waitSig(busy, 1'b0);
        chk("release", sendLead, 1'b0);
        repeat (40) @(negedge clk);
        $display("test outgoing done");
    endtask
    task automatic t_inc(input tss_sig_t sg, input tss_start_t md, input int lo,
        input int wid);
        int n;
        int w;
        n = 0;
        w = 0;
        cfg.sigType = sg;
        cfg.startMode = md;
        offHook = 1'b1;
        while (sendLead !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        while (sendLead === 1'b1 && w < 300)
        begin
            @(negedge clk);
            w++;
        end
        chk("farSeized", farSeized, 1'b1);
        if (wid == 0)
            chk("noStart", n[15:0], 16'd300);
        else
        begin
            chk("startWidth", w[15:0], wid[15:0]);
            chk("startLag", n >= lo && n <= lo + 24, 1'b1);
        end
        offHook = 1'b0;
        waitSig(busy, 1'b0);
        chk("idle", sendLead, 1'b0);
        $display("test incoming mode %0d done", md);
    endtask
    task automatic t_echo();
        cfg.echoReq = 1'b1;
        cfg.sigType = TYPE_TWO;
        repeat (3) @(negedge clk);
        chk("echoII", echoEn, 1'b0);
        cfg.sigType = TYPE_ONE;
        repeat (3) @(negedge clk);
        chk("echoI", echoEn, 1'b1);
        cfg.echoReq = 1'b0;
        $display("test echo done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #400000;
        fails++;
        print_verdict();
    end
    initial
    begin
        fails = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        cfg = '0;
        offHook = 1'b0;
        seizeReq = 1'b0;
        releaseReq = 1'b0;
        digitStb = 1'b0;
        digitVal = 4'h0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("resetIdle", {sendLead, busy, answered}, 3'h0);
        t_out();
        t_inc(TYPE_ONE, immediate_start_code, 0, 0);
        t_inc(TYPE_ONE, delay_dial_code, 0, Dly);
        t_inc(TYPE_ONE, wink_start_code, Lag, Wink_start_code);
        t_inc(TYPE_TWO, delay_dial_code, 0, Dly);
        t_inc(duplex_lead_signaling, wink_start_code, Lag, Wink_start_code);
        t_echo();
        print_verdict();
    end
endmodule
`default_nettype wire
